// ---- logic/rst_pkg.sv ----
// Constants and types shared by the brown-out and shared reset pin logic.
package rst_pkg;
    // ========================================================================
    // Timing
    // ========================================================================
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned RST_SEQ_NS    = 1000;
    localparam int unsigned RST_SEQ_CYC   = (RST_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ========================================================================
    // Reset cause register fields
    // ========================================================================
    localparam int unsigned CAUSE_W       = 8;
    localparam int unsigned CAUSE_POR_BIT = 7;
    localparam int unsigned CAUSE_EXT_BIT = 4;
    localparam logic [7:0]  CAUSE_RESET   = 8'h00;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_SEQ,
        ST_RUN
    } seq_state_e;
endpackage

// ---- logic/brownout_reset.sv ----
// Brown-out detection, system reset sequencing and the shared reset pin.
module brownout_reset #(
    parameter int unsigned SEQ_CYCLES = rst_pkg::RST_SEQ_CYC,
    parameter bit          SMALL_PKG  = 1'b0
) (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    // Analog indications
    input  wire logic                       brownout_detector,
    input  wire logic                       below_por_threshold,
    input  wire logic                       stop_mode,
    input  wire logic                       brownout_stop_keep_option,
    // Software pin configuration
    input  wire logic                       pin_gpio_sel,
    input  wire logic                       pin_gpio_oe,
    input  wire logic                       pin_gpio_out,
    input  wire logic                       cause_clear,
    // Shared reset pin
    input  wire logic                       reset_pin_in,
    output logic                            reset_pin_out,
    output logic                            reset_pin_oe_n,
    // Status
    output logic                            sys_reset,
    output logic                            pin_gpio_active,
    output logic                            pin_gpio_in,
    output logic [rst_pkg::CAUSE_W-1:0]     reset_cause_register
);
    import rst_pkg::*;

    // ========================================================================
    // Reset sources
    // ========================================================================
    logic bo_armed;
    logic bo_trip;
    logic pin_rst_fn;
    logic ext_hold;
    logic hold_req;

    // The detector may be switched off only while STOP mode is active.
    assign bo_armed   = !stop_mode || brownout_stop_keep_option;
    assign bo_trip    = bo_armed && brownout_detector;
    // During any system reset the pin is forced back to reset function, so
    // software selection only counts once the device runs.
    assign pin_rst_fn = sys_reset || !pin_gpio_sel;
    assign ext_hold   = pin_rst_fn && !reset_pin_in;
    assign hold_req   = bo_trip || below_por_threshold || ext_hold;

    // ========================================================================
    // Sequencer
    // ========================================================================
    localparam int unsigned CNT_W = $clog2(SEQ_CYCLES + 1);

    seq_state_e         state_reg, state_next;
    logic [CNT_W-1:0]   cnt_reg, cnt_next;
    logic               por_pend_reg, por_pend_next;
    logic               ext_pend_reg, ext_pend_next;
    logic [CAUSE_W-1:0] cause_reg, cause_next;

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        por_pend_next = por_pend_reg || bo_trip || below_por_threshold;
        ext_pend_next = ext_pend_reg || (ext_hold && !bo_trip && !below_por_threshold);
        cause_next    = cause_reg;
        if (cause_clear) begin
            cause_next = CAUSE_RESET;
        end
        unique case (state_reg)
            ST_HOLD: begin
                cnt_next = '0;
                if (!hold_req) begin
                    state_next = ST_SEQ;
                end
            end
            ST_SEQ: begin
                if (hold_req) begin
                    state_next = ST_HOLD;
                end else if (cnt_reg == CNT_W'(SEQ_CYCLES - 1)) begin
                    state_next    = ST_RUN;
                    por_pend_next = 1'b0;
                    ext_pend_next = 1'b0;
                    // A completed sequence sets the cause even against a clear.
                    if (por_pend_reg) begin
                        cause_next[CAUSE_POR_BIT] = 1'b1;
                    end else if (ext_pend_reg) begin
                        cause_next[CAUSE_EXT_BIT] = 1'b1;
                    end
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            ST_RUN: begin
                if (hold_req) begin
                    state_next = ST_HOLD;
                end
            end
        endcase
    end

    // Power comes up through the power-on path, so reset pends a POR cause.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg    <= ST_HOLD;
            cnt_reg      <= '0;
            por_pend_reg <= 1'b1;
            ext_pend_reg <= 1'b0;
            cause_reg    <= CAUSE_RESET;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            por_pend_reg <= por_pend_next;
            ext_pend_reg <= ext_pend_next;
            cause_reg    <= cause_next;
        end
    end

    assign sys_reset            = (state_reg != ST_RUN);
    assign reset_cause_register = cause_reg;

    // ========================================================================
    // Shared pin drive
    // ========================================================================
    logic drive_low;
    logic gpio_in_reg, gpio_in_next;

    assign pin_gpio_active = !pin_rst_fn;
    // Large package: GPIO is open-drain out only, no pull-up or stop recovery
    // exists, so only a low is ever driven and the input is not offered.
    always_comb begin
        drive_low    = 1'b0;
        gpio_in_next = 1'b0;
        if (pin_rst_fn) begin
            drive_low = sys_reset;
        end else if (SMALL_PKG) begin
            gpio_in_next = reset_pin_in;
            drive_low    = pin_gpio_oe && !pin_gpio_out;
        end else begin
            drive_low = !pin_gpio_out;
        end
    end

    // The pin level reaches software through a flop, so a read sees a value
    // that stands for a whole cycle; the price is one cycle of latency.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            gpio_in_reg <= 1'b0;
        end else begin
            gpio_in_reg <= gpio_in_next;
        end
    end

    assign pin_gpio_in = gpio_in_reg;

    // The small package drives a high in GPIO output mode; everything else is
    // open-drain and only ever pulls low.
    assign reset_pin_out  = (SMALL_PKG && !pin_rst_fn) ? pin_gpio_out : 1'b0;
    assign reset_pin_oe_n = (SMALL_PKG && !pin_rst_fn && pin_gpio_oe) ? 1'b0 : !drive_low;

    // ========================================================================
    // Checks
    // ========================================================================
    sequence supply_ok_s;
        !hold_req;
    endsequence

    sequence seq_done_s;
        state_reg == ST_SEQ && !hold_req && cnt_reg == CNT_W'(SEQ_CYCLES - 1);
    endsequence

    brownout_enters_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        bo_trip |=> state_reg == ST_HOLD)
        else $error("Brown-out did not force reset.");

    low_supply_holds_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        below_por_threshold |=> sys_reset)
        else $error("Low supply did not hold reset.");

    full_sequence_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(state_reg == ST_RUN) |-> $past(state_reg) == ST_SEQ)
        else $error("Run entered without full sequence.");

    por_flag_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        seq_done_s and por_pend_reg |=> cause_reg[CAUSE_POR_BIT])
        else $error("Power-on flag not set.");

    stop_option_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        stop_mode && !brownout_stop_keep_option && brownout_detector
        && !below_por_threshold && !ext_hold && state_reg == ST_RUN |=> state_reg == ST_RUN)
        else $error("Detector active in STOP despite option.");

    pin_reset_fn_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        sys_reset |-> !pin_gpio_active)
        else $error("Pin not in reset function during reset.");

    pin_hold_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        ext_hold ##1 supply_ok_s |-> sys_reset)
        else $error("Pin held low but reset released.");

    pin_pull_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        sys_reset |-> !reset_pin_oe_n && !reset_pin_out)
        else $error("Pin not pulled low during reset.");

    large_od_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !SMALL_PKG && pin_gpio_active && pin_gpio_out |-> reset_pin_oe_n)
        else $error("Large-package pin drove high.");

    // ========================================================================
    // Check helpers
    // ========================================================================
    // Counts the cycles spent in the sequence on its own, so the length of a
    // completed sequence is checked without a long repetition in a property.
    logic [CNT_W-1:0] seq_len_reg, seq_len_next;

    always_comb begin
        seq_len_next = '0;
        if (state_reg == ST_SEQ && seq_len_reg != CNT_W'(SEQ_CYCLES)) begin
            seq_len_next = seq_len_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            seq_len_reg <= '0;
        end else begin
            seq_len_reg <= seq_len_next;
        end
    end

    // Named steps that the properties below are built from.
    sequence run_entry_s;
        $rose(state_reg == ST_RUN);
    endsequence

    sequence pin_low_s;
        pin_rst_fn && !reset_pin_in;
    endsequence

    seq_length_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        run_entry_s |-> seq_len_reg == CNT_W'(SEQ_CYCLES))
        else $error("Run entered before the full sequence length.");

    seq_abort_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state_reg == ST_SEQ && hold_req |=> state_reg == ST_HOLD)
        else $error("Hold source did not restart the sequence.");

    hold_stays_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state_reg == ST_HOLD && hold_req |=> state_reg == ST_HOLD)
        else $error("Reset left while a hold source stood.");

    stop_kept_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        stop_mode && brownout_stop_keep_option && brownout_detector |=> sys_reset)
        else $error("Kept detector ignored in STOP.");

    pin_enter_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state_reg == ST_RUN ##0 pin_low_s |=> state_reg == ST_HOLD)
        else $error("Pin low did not enter reset.");

    ext_flag_set_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        seq_done_s and !por_pend_reg && ext_pend_reg |=> cause_reg[CAUSE_EXT_BIT])
        else $error("Pin cause flag not set.");

    cause_clear_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        cause_clear && state_reg == ST_RUN |=> cause_reg == CAUSE_RESET)
        else $error("Cause register not cleared.");

    cause_keep_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state_reg != ST_SEQ && !cause_clear |=> cause_reg == $past(cause_reg))
        else $error("Cause register changed without a cause.");

    pin_release_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !sys_reset && !pin_gpio_active |-> reset_pin_oe_n)
        else $error("Pin pulled low outside reset.");

    gpio_blocked_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        sys_reset && pin_gpio_sel |-> !pin_gpio_active && !reset_pin_out)
        else $error("Software pin selection honoured during reset.");

    boot_fn_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        state_reg == ST_HOLD |-> !pin_gpio_active && !reset_pin_oe_n)
        else $error("Pin left reset function before the device ran.");

    small_out_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        SMALL_PKG && pin_gpio_active && pin_gpio_oe
        |-> !reset_pin_oe_n && reset_pin_out == pin_gpio_out)
        else $error("Small-package pin did not drive its output.");

    small_in_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        SMALL_PKG && pin_gpio_active && !pin_gpio_oe
        |=> pin_gpio_in == $past(reset_pin_in))
        else $error("Small-package pin input not passed on.");

    small_float_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        SMALL_PKG && pin_gpio_active && !pin_gpio_oe |-> reset_pin_oe_n)
        else $error("Small-package input pin was driven.");

    large_low_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !SMALL_PKG && pin_gpio_active && !pin_gpio_out |-> !reset_pin_oe_n)
        else $error("Large-package pin did not pull low.");

    large_no_in_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !SMALL_PKG |-> !pin_gpio_in && !reset_pin_out)
        else $error("Large-package pin offered input or high drive.");
endmodule

// ---- verif/reset_pin_partner.sv ----
// Board side of the shared reset pin: an external reset source and a pull-up.
module reset_pin_partner (
    // Device pin drive
    input  wire logic dev_out,
    input  wire logic dev_oe_n,
    // Bench command
    input  wire logic ext_low,
    // Pin levels
    output logic      pin_in,
    output logic      pin_wire
);
    timeunit 1ns;
    timeprecision 100ps;
    // The source pulls low only on command, never on its own during a reset.
    assign pin_in   = !ext_low;
    // Wired-AND of the pull-up, the source and the device's open drain.
    assign pin_wire = pin_in && !(!dev_oe_n && !dev_out);
endmodule

// ---- verif/brownout_and_shared_reset_pin_tb_top.sv ----
// Self-checking testbench for the brown-out and shared reset pin logic.
module brownout_and_shared_reset_pin_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import rst_pkg::*;
    localparam int SEQ = 4;
    logic sys_clk = 0, resetn = 0, cause_clear = 0, ext_low = 0;
    logic brownout_detector = 0, below_por_threshold = 0, stop_mode = 0;
    logic brownout_stop_keep_option = 0, pin_gpio_sel = 0, pin_gpio_oe = 0, pin_gpio_out = 0;
    wire logic reset_pin_in, reset_pin_out, reset_pin_oe_n, sys_reset;
    wire logic pin_gpio_active, pin_gpio_in, pin_wire;
    wire logic lg_out, lg_oe_n, lg_rst, lg_gpio_in;
    wire logic [CAUSE_W-1:0] reset_cause_register;
    int n_mismatch = 0, total_checks = 0, cyc = 0, n;
    always #2.5 sys_clk = ~sys_clk;
    brownout_reset #(.SEQ_CYCLES(SEQ), .SMALL_PKG(1'b1)) uut (.sys_clk, .resetn,
        .brownout_detector, .below_por_threshold, .stop_mode, .brownout_stop_keep_option,
        .pin_gpio_sel, .pin_gpio_oe, .pin_gpio_out, .cause_clear, .reset_pin_in,
        .reset_pin_out, .reset_pin_oe_n, .sys_reset, .pin_gpio_active, .pin_gpio_in,
        .reset_cause_register);
    reset_pin_partner board (.dev_out(reset_pin_out), .dev_oe_n(reset_pin_oe_n),
        .ext_low(ext_low), .pin_in(reset_pin_in), .pin_wire(pin_wire));
    // Large-package build on the same inputs, for the open-drain-only pin.
    brownout_reset #(.SEQ_CYCLES(SEQ), .SMALL_PKG(1'b0)) uut_large (.sys_clk, .resetn,
        .brownout_detector, .below_por_threshold, .stop_mode, .brownout_stop_keep_option,
        .pin_gpio_sel, .pin_gpio_oe, .pin_gpio_out, .cause_clear, .reset_pin_in,
        .reset_pin_out(lg_out), .reset_pin_oe_n(lg_oe_n), .sys_reset(lg_rst),
        .pin_gpio_active(), .pin_gpio_in(lg_gpio_in), .reset_cause_register());
    // ========================================================================
    // Helpers
    // ========================================================================
    task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // Counts edges from the last hold source clearing until the device runs.
    task wait_rel();
        n = 0;
        do begin
            step(1);
            n++;
        end while (sys_reset === 1'b1 && n < 50);
        chk("release edges", n[7:0], 8'(SEQ + 1));
    endtask
    task pulse_clear();
        cause_clear = 1;
        step(1);
        cause_clear = 0;
    endtask
    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ========================================================================
    // Reference model
    // ========================================================================
    // Clean edges still owed before release, pending causes and cause bits.
    int m_left = SEQ + 1, m_rst = 1, m_por = 1, m_ext = 0, m_cause = 0;
    int m_bo, m_pin, m_hold;
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            m_left = SEQ + 1;
            m_rst = 1;
            m_por = 1;
            m_ext = 0;
            m_cause = 0;
        end else begin
            m_bo = brownout_detector && (!stop_mode || brownout_stop_keep_option);
            m_pin = (m_rst || !pin_gpio_sel) && ext_low;
            m_hold = m_bo || below_por_threshold || m_pin;
            m_por = m_por || m_bo || below_por_threshold;
            m_ext = m_ext || (m_pin && !m_bo && !below_por_threshold);
            if (cause_clear) m_cause = 0;
            if (m_hold) begin
                m_rst = 1;
                m_left = SEQ + 1;
            end else if (m_rst) begin
                m_left--;
                if (m_left == 0) begin
                    m_rst = 0;
                    if (m_por) m_cause = m_cause | 8'h80;
                    else if (m_ext) m_cause = m_cause | 8'h10;
                    m_por = 0;
                    m_ext = 0;
                end
            end
        end
    end
    always @(negedge sys_clk) begin
        chk("model reset", sys_reset, 8'(m_rst));
        chk("large reset", lg_rst, 8'(m_rst));
        chk("model cause", reset_cause_register, 8'(m_cause));
    end
    // ========================================================================
    // Scenarios
    // ========================================================================
    initial begin
        void'($urandom(32'h9a54_000b));
        step(4);
        chk("oe_n in reset", reset_pin_oe_n, 8'h00);
        chk("gpio at power-up", pin_gpio_active, 8'h00);
        resetn = 1;
        wait_rel();
        chk("cause after por", reset_cause_register, 8'h80);
        chk("pin released", reset_pin_oe_n, 8'h01);
        for (int s = 0; s < 2; s++) begin
            pulse_clear();
            chk("cause cleared", reset_cause_register, 8'h00);
            brownout_detector = (s == 0);
            below_por_threshold = (s == 1);
            step(2);
            chk("enter reset", sys_reset, 8'h01);
            step($urandom_range(2, 9));
            chk("held low supply", sys_reset, 8'h01);
            brownout_detector = 0;
            below_por_threshold = 0;
            if (s == 1) begin
                step(2);
                below_por_threshold = 1;
                step(1);
                chk("restart", sys_reset, 8'h01);
                below_por_threshold = 0;
            end
            wait_rel();
            chk("cause after brownout", reset_cause_register, 8'h80);
        end
        for (int o = 0; o < 2; o++) begin
            stop_mode = 1;
            brownout_stop_keep_option = o[0];
            brownout_detector = 1;
            step(3);
            chk("stop option", sys_reset, 8'(o));
            brownout_detector = 0;
            stop_mode = 0;
            if (o == 1) wait_rel();
        end
        pulse_clear();
        ext_low = 1;
        step(3);
        chk("pin reset", sys_reset, 8'h01);
        chk("pin wire low", pin_wire, 8'h00);
        step(5);
        chk("pin still held", sys_reset, 8'h01);
        ext_low = 0;
        wait_rel();
        chk("cause pin", reset_cause_register, 8'h10);
        pin_gpio_sel = 1;
        step(1);
        chk("gpio active", pin_gpio_active, 8'h01);
        repeat (6) begin
            pin_gpio_oe = 1'($urandom);
            pin_gpio_out = 1'($urandom);
            ext_low = pin_gpio_oe ? 1'b0 : 1'($urandom);
            step(1);
            chk("gpio oe_n", reset_pin_oe_n, 8'(!pin_gpio_oe));
            if (pin_gpio_oe) chk("gpio out", reset_pin_out, 8'(pin_gpio_out));
            else chk("gpio in", pin_gpio_in, 8'(!ext_low));
            chk("large oe_n", lg_oe_n, 8'(pin_gpio_out));
            chk("large drive", lg_out, 8'h00);
            chk("large input", lg_gpio_in, 8'h00);
        end
        ext_low = 0;
        brownout_detector = 1;
        step(2);
        chk("revert in reset", pin_gpio_active, 8'h00);
        chk("revert drive", reset_pin_oe_n, 8'h00);
        brownout_detector = 0;
        wait_rel();
        finish_test();
    end
endmodule
